// *** pac_output_ctrl.v ***
// Digital side of a pipelined sampling converter with its Avalon-MM register slave.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pac_map.vh"
module pac_output_ctrl #(
  parameter AIN_W = 14
) (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Encode clock pins
  input wire i_sample_clock_pos,
  input wire i_sample_clock_neg,
  // Digitised analog input, signed
  input wire [AIN_W-1:0] i_ain,
  // Avalon-MM slave
  input wire [`PAC_ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Interrupt
  output wire o_irq,
  // Output pins
  output wire [`PAC_DATA_W-1:0] o_sample_word_bits,
  output wire o_sample_word_bits_oe,
  output wire o_range_exceeded_flag,
  output wire o_range_exceeded_flag_oe,
  output wire o_data_valid_strobe,
  output wire o_data_valid_strobe_oe
);
  localparam DW = `PAC_DATA_W;
  localparam signed [AIN_W-1:0] AIN_MAX = 2047;
  localparam signed [AIN_W-1:0] AIN_MIN = -2048;

  reg pos_s1_q;
  reg pos_s2_q;
  reg neg_s1_q;
  reg neg_s2_q;
  reg [AIN_W-1:0] ain_s1_q;
  reg [AIN_W-1:0] ain_s2_q;
  reg enc_q;
  reg [3:0] ctrl_q;
  reg [1:0] int_status_q;
  reg [1:0] int_mask_q;
  reg ack_q;
  reg [DW-1:0] hold_q;
  reg hold_ovf_q;
  reg [DW-1:0] align1_q;
  reg [DW-1:0] align2_q;
  reg align1_ovf_q;
  reg align2_ovf_q;
  reg [DW-1:0] word_q;
  reg ovf_q;
  reg strobe_q;
  reg [1:0] int_status_d;
  reg [31:0] readdata_d;

  wire enc;
  wire rise;
  wire fall;
  wire power_down;
  wire out_disable;
  wire converting;
  wire twos;
  wire stabilizer;
  wire wr_ack;
  wire rd_take;
  wire signed [AIN_W-1:0] ain;
  wire ain_hi;
  wire ain_lo;
  wire [DW-1:0] ain_code;

  // Pins from outside the clock domain pass two flip-flops before any logic.
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
      ain_s1_q <= {AIN_W{1'b0}};
      ain_s2_q <= {AIN_W{1'b0}};
      enc_q <= 1'b0;
    end
    else
    begin
      pos_s1_q <= i_sample_clock_pos;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= i_sample_clock_neg;
      neg_s2_q <= neg_s1_q;
      ain_s1_q <= i_ain;
      ain_s2_q <= ain_s1_q;
      enc_q <= enc;
    end
  end

  // Equal levels count as low, so a floating pair never samples.
  assign enc = pos_s2_q & ~neg_s2_q;
  assign rise = enc & ~enc_q;
  assign fall = ~enc & enc_q;

  assign power_down = ctrl_q[`PAC_CTRL_PDS];
  assign out_disable = ctrl_q[`PAC_CTRL_OEN];
  assign converting = ~power_down;
  // Levels 2 and 3 are two's complement; the middle levels enable the stabilizer.
  assign twos = ctrl_q[`PAC_CTRL_MODE_HI];
  assign stabilizer = ctrl_q[`PAC_CTRL_MODE_HI] ^ ctrl_q[`PAC_CTRL_MODE_LO];

  // Clamp to the 12-bit range; adding half scale is the same as flipping bit 11.
  assign ain = ain_s2_q;
  assign ain_hi = ain > AIN_MAX;
  assign ain_lo = ain < AIN_MIN;
  assign ain_code = ain_hi ? {DW{1'b1}} : (ain_lo ? {DW{1'b0}} : (ain[DW-1:0] ^ 12'h800));

  // The held input is taken at each encode rise while converting and stays put through the whole period until the next such rise.
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hold_q <= {DW{1'b0}};
      hold_ovf_q <= 1'b0;
    end
    else if (converting && rise)
    begin
      hold_q <= ain_code;
      hold_ovf_q <= ain_hi | ain_lo;
    end
  end

  // Five stages, 3+3+2+2+2 bits; stages 0, 2 and 4 move on the falling phase, 1 and 3 on the rising.
  wire [DW-1:0] res_w [0:5];
  wire [DW-1:0] code_w [0:5];
  wire ovf_w [0:5];
  assign res_w[0] = hold_q;
  assign code_w[0] = {DW{1'b0}};
  assign ovf_w[0] = hold_ovf_q;

  genvar g;
  generate
    for (g = 0; g < `PAC_LATENCY; g = g + 1)
    begin : g_stage
      pac_stage #(
        .W(DW),
        .K((g < 2) ? 3 : 2)
      ) u_stage (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_en(converting & ((g % 2 == 0) ? fall : rise)),
        .i_res(res_w[g]),
        .i_code(code_w[g]),
        .i_ovf(ovf_w[g]),
        .o_res(res_w[g+1]),
        .o_code(code_w[g+1]),
        .o_ovf(ovf_w[g+1])
      );
    end
  endgenerate

  // Hold at rise n, last stage at fall n+2, then three rising edges to the pins at rise n+5.
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      align1_q <= {DW{1'b0}};
      align2_q <= {DW{1'b0}};
      align1_ovf_q <= 1'b0;
      align2_ovf_q <= 1'b0;
      word_q <= {DW{1'b0}};
      ovf_q <= 1'b0;
    end
    else if (converting && rise)
    begin
      align1_q <= code_w[`PAC_LATENCY];
      align1_ovf_q <= ovf_w[`PAC_LATENCY];
      align2_q <= align1_q;
      align2_ovf_q <= align1_ovf_q;
      word_q <= {align2_q[DW-1] ^ twos, align2_q[DW-2:0]};
      ovf_q <= align2_ovf_q;
    end
  end

  // The strobe rises with new data and falls at mid-cycle, where the receiver latches.
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      strobe_q <= 1'b0;
    else if (!converting)
      strobe_q <= 1'b0;
    else if (rise)
      strobe_q <= 1'b1;
    else if (fall)
      strobe_q <= 1'b0;
  end

  assign o_sample_word_bits = word_q;
  assign o_range_exceeded_flag = ovf_q;
  assign o_data_valid_strobe = strobe_q;
  assign o_sample_word_bits_oe = converting & ~out_disable;
  assign o_range_exceeded_flag_oe = converting & ~out_disable;
  assign o_data_valid_strobe_oe = converting & ~out_disable;

  // Every access takes one wait cycle, so read data always come from a register.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_ack = i_avs_write & ack_q;
  assign rd_take = i_avs_read & ~ack_q;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ack_q <= 1'b0;
    else
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_q <= `PAC_CTRL_RESET;
      int_mask_q <= `PAC_INT_RESET;
    end
    else if (wr_ack)
    begin
      if (i_avs_address == `PAC_OFS_CTRL)
        ctrl_q <= i_avs_writedata[3:0];
      if (i_avs_address == `PAC_OFS_INT_MASK)
        int_mask_q <= i_avs_writedata[1:0];
    end
  end

  // A new event in the cycle of a write-one clear keeps its bit set.
  always @*
  begin
    int_status_d = int_status_q;
    if (wr_ack && i_avs_address == `PAC_OFS_INT_STATUS)
      int_status_d = int_status_q & ~i_avs_writedata[1:0];
    if (converting && rise)
    begin
      int_status_d[`PAC_INT_WORD] = 1'b1;
      if (align2_ovf_q)
        int_status_d[`PAC_INT_OVF] = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      int_status_q <= `PAC_INT_RESET;
    else
      int_status_q <= int_status_d;
  end

  assign o_irq = |(int_status_q & int_mask_q);

  always @*
  begin
    readdata_d = 32'h0000_0000;
    case (i_avs_address)
      `PAC_OFS_CTRL: readdata_d[3:0] = ctrl_q;
      `PAC_OFS_STATUS:
      begin
        readdata_d[`PAC_ST_CONVERTING] = converting;
        readdata_d[`PAC_ST_DRIVING] = converting & ~out_disable;
        readdata_d[`PAC_ST_TWOS] = twos;
        readdata_d[`PAC_ST_STABILIZER] = stabilizer;
        readdata_d[`PAC_ST_NAP] = power_down & ~out_disable;
        readdata_d[`PAC_ST_SLEEP] = power_down & out_disable;
      end
      `PAC_OFS_SAMPLE: readdata_d[`PAC_SAMPLE_OVF:0] = {ovf_q, word_q};
      `PAC_OFS_INT_STATUS: readdata_d[1:0] = int_status_q;
      `PAC_OFS_INT_MASK: readdata_d[1:0] = int_mask_q;
      default: readdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_avs_readdata <= 32'h0000_0000;
    else if (rd_take)
      o_avs_readdata <= readdata_d;
  end
endmodule // pac_output_ctrl

// *** pac_map.vh ***
// Register map, field positions and reset values of the converter output control block.
`ifndef PAC_MAP_VH
`define PAC_MAP_VH

`define PAC_ADDR_W 5
`define PAC_OFS_CTRL 5'h00
`define PAC_OFS_STATUS 5'h04
`define PAC_OFS_SAMPLE 5'h08
`define PAC_OFS_INT_STATUS 5'h0c
`define PAC_OFS_INT_MASK 5'h10

`define PAC_CTRL_PDS 0
`define PAC_CTRL_OEN 1
`define PAC_CTRL_MODE_LO 2
`define PAC_CTRL_MODE_HI 3
`define PAC_CTRL_RESET 4'h0

`define PAC_ST_CONVERTING 0
`define PAC_ST_DRIVING 1
`define PAC_ST_TWOS 2
`define PAC_ST_STABILIZER 3
`define PAC_ST_NAP 4
`define PAC_ST_SLEEP 5

`define PAC_SAMPLE_OVF 12

`define PAC_INT_WORD 0
`define PAC_INT_OVF 1
`define PAC_INT_RESET 2'h0

`define PAC_MODE_0V 2'h0
`define PAC_MODE_THIRD 2'h1
`define PAC_MODE_TWO_THIRDS 2'h2
`define PAC_MODE_FULL 2'h3

`define PAC_DATA_W 12
`define PAC_LATENCY 5

`endif

// *** pac_stage.v ***
// One pipelined conversion stage: resolves K bits and passes on the amplified residue.
`timescale 1ns/100ps
module pac_stage #(
  parameter W = 12,
  parameter K = 3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Phase enable
  input wire i_en,
  // From the previous stage
  input wire [W-1:0] i_res,
  input wire [W-1:0] i_code,
  input wire i_ovf,
  // To the next stage
  output wire [W-1:0] o_res,
  output wire [W-1:0] o_code,
  output wire o_ovf
);
  reg [W-1:0] res_q;
  reg [W-1:0] code_q;
  reg ovf_q;

  // The code word carries earlier stages' bits forward so all partials line up in time.
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      res_q <= {W{1'b0}};
      code_q <= {W{1'b0}};
      ovf_q <= 1'b0;
    end
    else if (i_en)
    begin
      res_q <= {i_res[W-K-1:0], {K{1'b0}}};
      code_q <= {i_code[W-K-1:0], i_res[W-1:W-K]};
      ovf_q <= i_ovf;
    end
  end

  assign o_res = res_q;
  assign o_code = code_q;
  assign o_ovf = ovf_q;
endmodule // pac_stage

// *** pac_output_ctrl_sva.sv ***
// Concurrent checks on the converter output control ports.
`timescale 1ns/100ps
module pac_output_ctrl_sva (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Encode pins and bus strobes
  input wire i_sample_clock_pos,
  input wire i_sample_clock_neg,
  input wire i_avs_read,
  input wire i_avs_write,
  // Watched outputs
  input wire o_avs_waitrequest,
  input wire [11:0] o_sample_word_bits,
  input wire o_sample_word_bits_oe,
  input wire o_range_exceeded_flag,
  input wire o_range_exceeded_flag_oe,
  input wire o_data_valid_strobe,
  input wire o_data_valid_strobe_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire enc = i_sample_clock_pos & ~i_sample_clock_neg;
  wire oe = o_sample_word_bits_oe;
  wire [11:0] w = o_sample_word_bits;
  // Five driven cycles give the pin synchroniser time to land before the strobe is judged.
  sequence s_rise;
    $rose(enc) ##0 oe [*5];
  endsequence
  sequence s_fall;
    $fell(enc) ##0 oe [*5];
  endsequence
  sequence s_req;
    $rose(i_avs_read | i_avs_write);
  endsequence
  property p_oe_same;
    oe == o_data_valid_strobe_oe && oe == o_range_exceeded_flag_oe;
  endproperty
  property p_rise;
    s_rise |-> o_data_valid_strobe;
  endproperty
  property p_fall;
    s_fall |-> !o_data_valid_strobe;
  endproperty
  property p_low;
    !enc [*6] |-> !o_data_valid_strobe;
  endproperty
  property p_word;
    $changed(w) |-> $rose(o_data_valid_strobe);
  endproperty
  property p_ovf;
    $changed(o_range_exceeded_flag) |-> $rose(o_data_valid_strobe);
  endproperty
  property p_clip;
    o_range_exceeded_flag |-> w == 12'h000 || w == 12'hfff || w == 12'h7ff || w == 12'h800;
  endproperty
  property p_wait;
    s_req |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("enables differ");
  a_rise: assert property (p_rise) else $error("strobe missed rise");
  a_fall: assert property (p_fall) else $error("strobe missed fall");
  a_low: assert property (p_low) else $error("strobe without encode");
  a_word: assert property (p_word) else $error("word moved off strobe");
  a_ovf: assert property (p_ovf) else $error("flag moved off strobe");
  a_clip: assert property (p_clip) else $error("flag on inner code");
  a_wait: assert property (p_wait) else $error("wait cycle count");
endmodule // pac_output_ctrl_sva
bind pac_output_ctrl pac_output_ctrl_sva u_sva (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_sample_clock_pos(i_sample_clock_pos),
  .i_sample_clock_neg(i_sample_clock_neg),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_sample_word_bits(o_sample_word_bits),
  .o_sample_word_bits_oe(o_sample_word_bits_oe),
  .o_range_exceeded_flag(o_range_exceeded_flag),
  .o_range_exceeded_flag_oe(o_range_exceeded_flag_oe),
  .o_data_valid_strobe(o_data_valid_strobe),
  .o_data_valid_strobe_oe(o_data_valid_strobe_oe)
);

// *** pac_rx_model.sv ***
// Receiving logic that latches each word on the falling data-valid strobe.
`timescale 1ns/100ps
module pac_rx_model (
  // Pins from the converter
  input wire [12:0] i_pins,
  input wire i_strobe,
  // Captured word and count
  output reg [12:0] o_word_q = 13'h0,
  output reg [7:0] o_count_q = 8'h0
);
  // Released pins float, so only fully driven words are taken.
  always @(negedge i_strobe)
  begin
    if (^i_pins !== 1'bx)
    begin
      o_word_q <= i_pins;
      o_count_q <= o_count_q + 8'h1;
    end
  end
endmodule // pac_rx_model

// *** pac_output_ctrl_test.sv ***
// Self-checking testbench of the converter output control block.
`timescale 1ns/100ps
`include "pac_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module pac_output_ctrl_test;
  reg i_clk = 0;
  reg i_nrst = 0;
  reg i_sample_clock_pos = 0;
  reg i_sample_clock_neg = 1;
  reg [13:0] i_ain = 0;
  reg [4:0] i_avs_address = 0;
  reg i_avs_read = 0;
  reg i_avs_write = 0;
  reg [31:0] i_avs_writedata = 0;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest;
  wire o_irq;
  wire [11:0] o_sample_word_bits;
  wire o_sample_word_bits_oe;
  wire o_range_exceeded_flag;
  wire o_range_exceeded_flag_oe;
  wire o_data_valid_strobe;
  wire o_data_valid_strobe_oe;
  wire [12:0] pins = {o_range_exceeded_flag_oe ? o_range_exceeded_flag : 1'bz,
                      o_sample_word_bits_oe ? o_sample_word_bits : 12'hzzz};
  wire [12:0] rx_word;
  wire [7:0] rx_count;
  reg [31:0] r;
  integer errors = 0;
  integer checked = 0;
  always #10 i_clk = ~i_clk;
  pac_output_ctrl u_dut (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sample_clock_pos(i_sample_clock_pos),
    .i_sample_clock_neg(i_sample_clock_neg),
    .i_ain(i_ain),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq(o_irq),
    .o_sample_word_bits(o_sample_word_bits),
    .o_sample_word_bits_oe(o_sample_word_bits_oe),
    .o_range_exceeded_flag(o_range_exceeded_flag),
    .o_range_exceeded_flag_oe(o_range_exceeded_flag_oe),
    .o_data_valid_strobe(o_data_valid_strobe),
    .o_data_valid_strobe_oe(o_data_valid_strobe_oe)
  );
  pac_rx_model u_rx (.i_pins(pins), .i_strobe(o_data_valid_strobe), .o_word_q(rx_word), .o_count_q(rx_count));
  task end_of_test;
  begin
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task av(input w, input [4:0] a, input [31:0] d);
    integer i;
  begin
    @(posedge i_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i = 0;
    // Waitrequest and read data are judged at the rising edge itself, before that edge's updates land.
    @(posedge i_clk);
    while (o_avs_waitrequest && i < 20)
    begin
      @(posedge i_clk);
      i++;
    end
    r = o_avs_readdata;
    if (i == 20)
    begin
      errors++;
      end_of_test;
    end
    i_avs_read <= 0;
    i_avs_write <= 0;
    @(negedge i_clk);
  end
  endtask
  // One encode period is eight clocks, high for the first four.
  task enc(input p, input n, input integer k);
    integer j;
  begin
    for (j = 0; j < k; j++)
    begin
      @(posedge i_clk);
      i_sample_clock_pos <= p;
      i_sample_clock_neg <= n;
      repeat (4) @(posedge i_clk);
      i_sample_clock_pos <= 0;
      i_sample_clock_neg <= 1;
      repeat (3) @(posedge i_clk);
    end
  end
  endtask
  function [12:0] code(input integer v, input [1:0] m);
    reg [12:0] c;
  begin
    c = (v > 2047) ? 13'h1fff : (v < -2048) ? 13'h1000 : v + 2048;
    if (m[1])
      c[11] = ~c[11];
    code = c;
  end
  endfunction
  task t_reset;
    integer a;
  begin
    for (a = 0; a < 32; a = a + 4)
    begin
      av(0, a[4:0], 0);
      `CHK(r, (a == 4) ? 32'h3 : 32'h0)
    end
  end
  endtask
  task t_modes;
    integer m, v;
  begin
    for (m = 0; m < 4; m++)
    begin
      v = (m == 0) ? 1234 : (m == 1) ? -5 : (m == 2) ? 3000 : -3000;
      av(1, `PAC_OFS_CTRL, m << 2);
      i_ain <= v[13:0];
      enc(1, 0, 7);
      av(0, `PAC_OFS_STATUS, 0);
      `CHK(r[3:2], {m[0] ^ m[1], m[1]})
      `CHK(rx_word, code(v, m[1:0]))
      `CHK({o_range_exceeded_flag, o_sample_word_bits}, code(v, m[1:0]))
    end
  end
  endtask
  task t_latency;
    integer k;
  begin
    av(1, `PAC_OFS_CTRL, 0);
    i_ain <= 14'd100;
    enc(1, 0, 7);
    i_ain <= -14'sd100;
    for (k = 1; k <= 6; k++)
    begin
      enc(1, 0, 1);
      @(negedge i_clk);
      `CHK({o_range_exceeded_flag, o_sample_word_bits}, code(k < 6 ? 100 : -100, 2'd0))
    end
  end
  endtask
  task t_power;
    integer p, v;
  begin
    for (p = 0; p < 4; p++)
    begin
      av(1, `PAC_OFS_CTRL, p);
      v = p * 300;
      i_ain <= v[13:0];
      enc(1, 0, 7);
      `CHK(o_sample_word_bits_oe, p == 0)
      `CHK({o_range_exceeded_flag_oe, o_data_valid_strobe_oe}, {2{p == 0}})
      av(0, `PAC_OFS_SAMPLE, 0);
      `CHK(r[12:0], code(p[0] ? v - 300 : v, 2'd0))
      av(0, `PAC_OFS_STATUS, 0);
      `CHK(r[5:0], {p == 3, p == 1, 2'b0, p == 0, !p[0]})
    end
  end
  endtask
  task t_level;
    reg [7:0] c0;
  begin
    av(1, `PAC_OFS_CTRL, 0);
    c0 = rx_count;
    enc(1, 1, 2);
    enc(0, 0, 2);
    `CHK(rx_count, c0)
  end
  endtask
  task t_irq;
  begin
    av(1, `PAC_OFS_INT_STATUS, 3);
    av(1, `PAC_OFS_INT_MASK, 0);
    enc(1, 0, 1);
    av(0, `PAC_OFS_INT_STATUS, 0);
    `CHK(r[1:0], 2'h1)
    `CHK(o_irq, 1'b0)
    av(1, `PAC_OFS_INT_MASK, 2);
    `CHK(o_irq, 1'b0)
    av(1, `PAC_OFS_INT_MASK, 1);
    `CHK(o_irq, 1'b1)
    av(1, `PAC_OFS_INT_STATUS, 1);
    `CHK(o_irq, 1'b0)
  end
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1;
    t_reset;
    t_modes;
    t_latency;
    t_power;
    t_level;
    t_irq;
    end_of_test;
  end
endmodule // pac_output_ctrl_test
